// [rtl/wiper_port_pkg.sv]
package wiper_port_pkg;

	// ************************************************************
	// Word layout
	// ************************************************************
	localparam int WORD_W   = 16;
	localparam int CMD_HI   = 15;
	localparam int CMD_LO   = 12;
	localparam int ADDR_HI  = 11;
	localparam int ADDR_LO  = 8;
	localparam int DATA_HI  = 7;
	localparam int DATA_LO  = 0;
	localparam int A0_BIT   = 8;
	localparam int WIPERS   = 2;
	localparam int NV_WORDS = 16;

	// ************************************************************
	// Commands
	// ************************************************************
	localparam logic [3:0] CMD_NOP       = 4'h0;
	localparam logic [3:0] CMD_RELOAD1   = 4'h1;
	localparam logic [3:0] CMD_SAVE      = 4'h2;
	localparam logic [3:0] CMD_NV_WRITE  = 4'h3;
	localparam logic [3:0] CMD_SHR1      = 4'h4;
	localparam logic [3:0] CMD_SHR_ALL   = 4'h5;
	localparam logic [3:0] CMD_DEC1      = 4'h6;
	localparam logic [3:0] CMD_DEC_ALL   = 4'h7;
	localparam logic [3:0] CMD_RELOADALL = 4'h8;
	localparam logic [3:0] CMD_RD_NV     = 4'h9;
	localparam logic [3:0] CMD_RD_WIPER  = 4'hA;
	localparam logic [3:0] CMD_LOAD      = 4'hB;
	localparam logic [3:0] CMD_SHL1      = 4'hC;
	localparam logic [3:0] CMD_SHL_ALL   = 4'hD;
	localparam logic [3:0] CMD_INC1      = 4'hE;
	localparam logic [3:0] CMD_INC_ALL   = 4'hF;

	// ************************************************************
	// Reset values and timing
	// ************************************************************
	localparam logic [7:0]  MIDSCALE      = 8'h80;
	localparam logic [7:0]  USER_NV_RESET = 8'h00;
	localparam logic [15:0] WORD_RESET    = 16'h0000;
	localparam logic [4:0]  CNT_FULL      = 5'h10;
	localparam int          CLK_MHZ       = 200;
	localparam int          SAVE_TIME_US  = 25000;
	localparam int          SAVE_CYCLES   = SAVE_TIME_US * CLK_MHZ;
	localparam logic [22:0] SHORT_BUSY    = 23'h000001;

endpackage

// [rtl/wiper_port.sv]
`timescale 1ns/1ps
// Contract
// - Command 11 loads the data byte into the addressed wiper position register.
// - Command 2 copies the addressed wiper into nonvolatile memory; permanent after 25 ms.
// - At power-on each wiper reloads from its nonvolatile setting.
// - Nonvolatile wiper settings default to midscale before any save.
// - Preset pin low forces midscale; its rising edge reloads from nonvolatile memory.
// - A strobe with no new bits repeats the last step or shift command.
// - Write-protect low blocks serial wiper changes; reloads by 1, 8 or preset still work.
// - Each transfer is a 16-bit word, most significant bit first.
// - The word is decoded and executed only when chip select rises.
// - Word is 4-bit command, 4-bit address, 8-bit data.
// - Serial output is released whenever chip select is high.
// - Slave modes: clock idle high second edge, or idle low first edge.
// - Command 10 reads back a wiper, command 9 a nonvolatile word.
// - Other commands pass the shifted word on for daisy chaining.
// - One input bit is captured per serial clock rising edge.
// - Serial output carries the input stream delayed by 16 clocks.
// - A save locks the shift register and completion shows on the ready pin.
// - Ready pin marks completion of commands 2, 3, 8, 9, 10 and preset.
module wiper_port #(
	parameter int SAVE_CYC = wiper_port_pkg::SAVE_CYCLES
) (
	// Clock and reset
	input  wire logic       CLK,
	input  wire logic       RST_N,
	// Serial port pins
	input  wire logic       SCLK,
	input  wire logic       CS_N,
	input  wire logic       SERIAL_IN_PIN,
	output logic            SDO_O,
	output logic            SDO_OE,
	// Hardware control pins
	input  wire logic       PRESET_N,
	input  wire logic       WP_N,
	output logic            RDY_O,
	output logic            RDY_OE,
	// Wiper positions
	output logic [7:0]      WIPER0,
	output logic [7:0]      WIPER1
);

	// ************************************************************
	// Pin synchronisers
	// ************************************************************
	logic [4:0]  sync1_r;
	logic [4:0]  sync2_r;
	logic        sclk_d_r;
	logic        cs_d_r;
	logic        preset_d_r;
	logic        sclk_s;
	logic        cs_s;
	logic        sdi_s;
	logic        preset_s;
	logic        wp_s;

	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			sync1_r  <= 5'h1F;
			sync2_r  <= 5'h1F;
			sclk_d_r <= 1'b1;
			cs_d_r   <= 1'b1;
			preset_d_r <= 1'b1;
		end
		else
		begin
			sync1_r  <= {SCLK, CS_N, SERIAL_IN_PIN, PRESET_N, WP_N};
			sync2_r  <= sync1_r;
			sclk_d_r <= sclk_s;
			cs_d_r   <= cs_s;
			preset_d_r <= preset_s;
		end
	end

	assign {sclk_s, cs_s, sdi_s, preset_s, wp_s} = sync2_r;

	logic sclk_rise;
	logic cs_rise;
	logic preset_rise;
	assign sclk_rise   = sclk_s && !sclk_d_r;
	assign cs_rise     = cs_s && !cs_d_r;
	assign preset_rise = preset_s && !preset_d_r;

	// ************************************************************
	// Shift register, bit count and word selection
	// ************************************************************
	logic [15:0] shift_r;
	logic [15:0] last_r;
	logic [4:0]  cnt_r;
	logic [22:0] busy_r;
	logic        busy;
	logic [15:0] word;
	logic [3:0]  cmd;
	logic        exec;
	logic        wp_ok;
	logic [7:0]  wiper_r [wiper_port_pkg::WIPERS];
	logic [7:0]  nv_r [wiper_port_pkg::NV_WORDS];

	function automatic logic is_repeat(input logic [3:0] c);
		is_repeat = (c inside {[wiper_port_pkg::CMD_SHR1 : wiper_port_pkg::CMD_DEC_ALL],
			[wiper_port_pkg::CMD_SHL1 : wiper_port_pkg::CMD_INC_ALL]});
	endfunction

	assign busy  = (busy_r != 23'h000000);
	assign exec  = cs_rise;
	// An empty strobe reuses the previous word so push-button stepping needs no data.
	assign word  = (cnt_r == 5'h00 && is_repeat(last_r[wiper_port_pkg::CMD_HI:wiper_port_pkg::CMD_LO]))
		? last_r : shift_r;
	assign cmd   = word[wiper_port_pkg::CMD_HI:wiper_port_pkg::CMD_LO];
	assign wp_ok = wp_s;

	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			shift_r <= wiper_port_pkg::WORD_RESET;
			cnt_r   <= 5'h00;
		end
		else if (exec)
		begin
			cnt_r <= 5'h00;
			if (cmd == wiper_port_pkg::CMD_RD_WIPER)
				shift_r[7:0] <= wiper_r[word[wiper_port_pkg::A0_BIT]];
			else if (cmd == wiper_port_pkg::CMD_RD_NV)
				shift_r[7:0] <= nv_r[word[wiper_port_pkg::ADDR_HI:wiper_port_pkg::ADDR_LO]];
		end
		else if (sclk_rise && !cs_s && !busy)
		begin
			shift_r <= {shift_r[14:0], sdi_s};
			if (cnt_r != wiper_port_pkg::CNT_FULL)
				cnt_r <= cnt_r + 5'h01;
		end
	end

	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
			last_r <= wiper_port_pkg::WORD_RESET;
		else if (exec)
			last_r <= word;
	end

	// ************************************************************
	// Serial output and ready pin
	// ************************************************************
	// The output bit is the oldest bit held, so the stream leaves 16 clocks late.
	assign SDO_O  = 1'b0;
	assign SDO_OE = !cs_s && !shift_r[15];
	assign RDY_O  = 1'b0;
	assign RDY_OE = busy;

	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
			busy_r <= 23'h000000;
		else if (exec && wp_ok && (cmd == wiper_port_pkg::CMD_SAVE
			|| cmd == wiper_port_pkg::CMD_NV_WRITE))
			busy_r <= 23'(SAVE_CYC);
		else if ((exec && cmd inside {wiper_port_pkg::CMD_RELOADALL,
			wiper_port_pkg::CMD_RD_NV, wiper_port_pkg::CMD_RD_WIPER}) || preset_rise)
			busy_r <= wiper_port_pkg::SHORT_BUSY;
		else if (busy)
			busy_r <= busy_r - 23'h000001;
	end

	// ************************************************************
	// Nonvolatile setting memory
	// ************************************************************
	// Reset models the factory content; a real array would keep its value over power.
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			for (int i = 0; i < wiper_port_pkg::NV_WORDS; i++)
				nv_r[i] <= (i < wiper_port_pkg::WIPERS) ? wiper_port_pkg::MIDSCALE
					: wiper_port_pkg::USER_NV_RESET;
		end
		else if (exec && wp_ok && cmd == wiper_port_pkg::CMD_SAVE)
			nv_r[word[wiper_port_pkg::A0_BIT]] <= wiper_r[word[wiper_port_pkg::A0_BIT]];
		else if (exec && wp_ok && cmd == wiper_port_pkg::CMD_NV_WRITE)
			nv_r[word[wiper_port_pkg::ADDR_HI:wiper_port_pkg::ADDR_LO]] <=
				word[wiper_port_pkg::DATA_HI:wiper_port_pkg::DATA_LO];
	end

	// ************************************************************
	// Wiper position registers
	// ************************************************************
	logic reload_r;

	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
			reload_r <= 1'b1;
		else
			reload_r <= preset_rise;
	end

	function automatic logic [7:0] step(input logic [3:0] c, input logic [7:0] v);
		case (c)
			wiper_port_pkg::CMD_SHR1, wiper_port_pkg::CMD_SHR_ALL: step = {1'b0, v[7:1]};
			wiper_port_pkg::CMD_SHL1, wiper_port_pkg::CMD_SHL_ALL: step = {v[6:0], 1'b1};
			wiper_port_pkg::CMD_DEC1, wiper_port_pkg::CMD_DEC_ALL:
				step = (v == 8'h00) ? v : v - 8'h01;
			wiper_port_pkg::CMD_INC1, wiper_port_pkg::CMD_INC_ALL:
				step = (v == 8'hFF) ? v : v + 8'h01;
			default: step = v;
		endcase
	endfunction

	genvar gi;
	generate
		for (gi = 0; gi < wiper_port_pkg::WIPERS; gi++)
		begin : g_wiper
			logic hit;
			// Odd command codes of the step group act on every wiper.
			assign hit = (word[wiper_port_pkg::A0_BIT] == 1'(gi)) || cmd[0];

			always_ff @(posedge CLK or negedge RST_N)
			begin
				if (!RST_N)
					wiper_r[gi] <= wiper_port_pkg::MIDSCALE;
				else if (!preset_s)
					wiper_r[gi] <= wiper_port_pkg::MIDSCALE;
				else if (reload_r || (exec && cmd == wiper_port_pkg::CMD_RELOADALL)
					|| (exec && cmd == wiper_port_pkg::CMD_RELOAD1
					&& word[wiper_port_pkg::A0_BIT] == 1'(gi)))
					wiper_r[gi] <= nv_r[gi];
				else if (exec && wp_ok && cmd == wiper_port_pkg::CMD_LOAD
					&& word[wiper_port_pkg::A0_BIT] == 1'(gi))
					wiper_r[gi] <= word[wiper_port_pkg::DATA_HI:wiper_port_pkg::DATA_LO];
				else if (exec && wp_ok && hit && is_repeat(cmd))
					wiper_r[gi] <= step(cmd, wiper_r[gi]);
			end
		end
	endgenerate

	assign WIPER0 = wiper_r[0];
	assign WIPER1 = wiper_r[1];

	// ************************************************************
	// Assertions
	// ************************************************************
	AST_SDO_RELEASED: assert property (@(posedge CLK) disable iff (!RST_N)
		cs_s |-> !SDO_OE) else $error("Serial output driven with chip select high.");

	AST_NO_EARLY_EXEC: assert property (@(posedge CLK) disable iff (!RST_N)
		(!cs_rise && preset_s && !reload_r) |=> $stable(WIPER0))
		else $error("Wiper changed without a chip select rise.");

	AST_LOAD: assert property (@(posedge CLK) disable iff (!RST_N)
		(exec && preset_s && !reload_r && wp_s && cmd == wiper_port_pkg::CMD_LOAD && !word[8])
		|=> WIPER0 == $past(word[7:0])) else $error("Load command did not set the wiper.");

	AST_WP_BLOCK: assert property (@(posedge CLK) disable iff (!RST_N)
		(exec && preset_s && !reload_r && !wp_s && cmd == wiper_port_pkg::CMD_LOAD)
		|=> $stable(WIPER0) && $stable(WIPER1)) else $error("Load passed write protect.");

	AST_PRESET_MID: assert property (@(posedge CLK) disable iff (!RST_N)
		!preset_s |=> WIPER0 == wiper_port_pkg::MIDSCALE && WIPER1 == wiper_port_pkg::MIDSCALE)
		else $error("Preset low did not force midscale.");

	AST_SAVE_BUSY: assert property (@(posedge CLK) disable iff (!RST_N)
		(exec && wp_s && cmd == wiper_port_pkg::CMD_SAVE && !word[8])
		|=> RDY_OE && nv_r[0] == $past(WIPER0)) else $error("Save did not store or go busy.");

	AST_LOCK: assert property (@(posedge CLK) disable iff (!RST_N)
		(busy && !exec) |=> $stable(shift_r)) else $error("Shift register moved while busy.");

	AST_CAPTURE: assert property (@(posedge CLK) disable iff (!RST_N)
		(sclk_rise && !cs_s && !busy && !exec) |=> shift_r[0] == $past(sdi_s)
		&& shift_r[15:1] == $past(shift_r[14:0])) else $error("Serial bit not captured.");

	AST_READBACK: assert property (@(posedge CLK) disable iff (!RST_N)
		(exec && cmd == wiper_port_pkg::CMD_RD_WIPER && !word[8])
		|=> shift_r[7:0] == $past(WIPER0)) else $error("Wiper readback not loaded.");

endmodule

// [bench/spi_host_model.sv]
`timescale 1ns/1ps
// ************************************************************
// Serial host model
// ************************************************************
module spi_host_model (
	// Serial port pins
	output logic      SCLK,
	output logic      CS_N,
	output logic      SERIAL_IN_PIN,
	input  wire logic SDO_O,
	input  wire logic SDO_OE
);
	// The output is open drain, so a released line reads as the pull-up level.
	wire sdo_line = SDO_OE ? SDO_O : 1'b1;

	initial
	begin
		SCLK = 1'b0;
		CS_N = 1'b1;
		SERIAL_IN_PIN  = 1'b1;
	end

	// A frame of zero bits is an empty strobe. Input data is toggled after the frame so
	// that a stale level can never pass for a good one.
	task automatic xfer(input logic [31:0] w, input int n, output logic [31:0] rx);
		rx = 32'h0;
		CS_N = 1'b0;
		for (int i = n - 1; i >= 0; i--)
		begin
			SERIAL_IN_PIN = w[i];
			#24;
			SCLK = 1'b1;
			rx = {rx[30:0], sdo_line};
			#24;
			SCLK = 1'b0;
		end
		#24;
		CS_N = 1'b1;
		SERIAL_IN_PIN = ~SERIAL_IN_PIN;
	endtask
endmodule

// [bench/testbench.sv]
`timescale 1ns/1ps
module testbench;
	localparam int SAVE_CYC = 20;
	logic        clk, rst_n, preset_n, wp_n;
	logic        sclk, cs_n, serial_in_pin, sdo_o, sdo_oe, rdy_o, rdy_oe;
	logic [7:0]  wiper0, wiper1;
	logic [31:0] rx;
	int          error_cnt, cmp_count;

	wiper_port #(.SAVE_CYC(SAVE_CYC)) u_dut (.CLK(clk), .RST_N(rst_n), .SCLK(sclk),
		.CS_N(cs_n), .SERIAL_IN_PIN(serial_in_pin), .SDO_O(sdo_o), .SDO_OE(sdo_oe), .PRESET_N(preset_n),
		.WP_N(wp_n), .RDY_O(rdy_o), .RDY_OE(rdy_oe), .WIPER0(wiper0), .WIPER1(wiper1));
	spi_host_model u_host (.SCLK(sclk), .CS_N(cs_n), .SERIAL_IN_PIN(serial_in_pin), .SDO_O(sdo_o),
		.SDO_OE(sdo_oe));

	// ************************************************************
	// Helpers
	// ************************************************************
	task automatic stop_test();
		$display("Checks %0d, mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// Execution lands a few cycles after the strobe; busy must then clear in bounded time.
	task automatic send(input logic [31:0] w, input int n);
		u_host.xfer(w, n, rx);
		repeat (8) @(negedge clk);
		for (int k = 0; rdy_oe !== 1'b0; k++)
		begin
			if (k > 200)
			begin
				chk("busy", 0, 1);
				stop_test();
			end
			@(negedge clk);
		end
	endtask

	// ************************************************************
	// Scenarios
	// ************************************************************
	task automatic t_reset();
		chk("wiper0", 8'h80, wiper0);
		chk("wiper1", 8'h80, wiper1);
		chk("sdo_oe", 0, sdo_oe);
		chk("sdo_o", 0, sdo_o);
		chk("rdy_o", 0, rdy_o);
		chk("rdy_oe", 0, rdy_oe);
		$display("test reset done");
	endtask

	task automatic t_daisy();
		send(32'hB040, 16);
		chk("wiper0", 8'h40, wiper0);
		send(32'hB011_B122, 32);
		chk("wiper1", 8'h22, wiper1);
		chk("wiper0", 8'h40, wiper0);
		chk("sdo old", 16'hB040, rx[31:16]);
		chk("sdo pass", 16'hB011, rx[15:0]);
		$display("test daisy done");
	endtask

	task automatic t_steps();
		logic [19:0] tbl [8] = '{20'hEFFFF, 20'h60000, 20'hC4081, 20'h48140,
			20'hF1011, 20'h7100F, 20'hD2143, 20'h52110};
		for (int i = 0; i < 8; i++)
		begin
			send({16'h0, 8'hB0, tbl[i][15:8]}, 16);
			send({16'h0, 8'hB1, tbl[i][15:8]}, 16);
			send({16'h0, tbl[i][19:16], 12'h000}, 16);
			chk("step w0", tbl[i][7:0], wiper0);
			chk("step w1", tbl[i][16] ? tbl[i][7:0] : tbl[i][15:8], wiper1);
		end
		send(32'h0, 0);
		chk("repeat w0", 8'h08, wiper0);
		chk("repeat w1", 8'h08, wiper1);
		$display("test steps done");
	endtask

	task automatic t_wp();
		@(negedge clk);
		wp_n = 1'b0;
		repeat (4) @(negedge clk);
		send(32'hB155, 16);
		chk("wp w1", 8'h08, wiper1);
		send(32'h8000, 16);
		chk("wp reload", 8'h80, wiper1);
		send(32'h0000, 16);
		wp_n = 1'b1;
		repeat (4) @(negedge clk);
		$display("test protect done");
	endtask

	task automatic t_save();
		int cnt;
		cnt = 0;
		send(32'hB033, 16);
		u_host.xfer(32'h2000, 16, rx);
		for (int k = 0; k < 200; k++)
		begin
			@(negedge clk);
			if (rdy_oe === 1'b1)
				cnt++;
			else if (cnt > 0)
				break;
		end
		chk("save busy", SAVE_CYC, cnt);
		send(32'hB099, 16);
		preset_n = 1'b0;
		repeat (8) @(negedge clk);
		chk("preset low", 8'h80, wiper0);
		preset_n = 1'b1;
		repeat (8) @(negedge clk);
		chk("preset rise", 8'h33, wiper0);
		send(32'hA000, 16);
		send(32'h0000, 16);
		chk("read wiper", 16'hA033, rx[15:0]);
		send(32'h9100, 16);
		send(32'h0000, 16);
		chk("read nv", 16'h9180, rx[15:0]);
		$display("test save done");
	endtask

	// ************************************************************
	// Main sequence
	// ************************************************************
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	initial
	begin
		error_cnt = 0;
		cmp_count = 0;
		rst_n = 1'b0;
		preset_n = 1'b1;
		wp_n = 1'b1;
		repeat (12) @(negedge clk);
		rst_n = 1'b1;
		repeat (4) @(negedge clk);
		t_reset();
		t_daisy();
		t_steps();
		t_wp();
		t_save();
		stop_test();
	end
endmodule
